/* design/cic_top.sv */
// CPU interrupt control unit: control register, arbitration rounds, interrupt take
//
// Behaviour
// - Vector entry follows winning priority number
// - Software request set raises real interrupt
// - Software and hardware requests behave identically
// - Four software-only request nodes
// - Priority one is lowest valid, entry one
// - Higher pending request served right after return
// - Priority one taken on return to zero
// - Pending field read-only, set each round end
// - Pending field zero at round start, idle
// - Bits 26:24 arbitration control, bits 31:27 and 15:9 reserved
// - Global enable, node enable, CPU state gate
// - Taking interrupt clears global enable
// - Return restores previous global enable
// - Enable, disable, move, begin-routine change enable
// - CPU priority updated on entry, exit, begin-routine
// - Move instruction writes CPU priority
// - Control register resets to zero
// - Vector is priority shifted five, ORed base
// - Take loads CPU priority with taken priority
// - Only priorities above CPU priority taken
`timescale 1ns/100ps
`default_nettype none
`include "cic_defines.svh"
module cic_top (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              resetn,
  // Core special register access
  input  wire logic              csr_wr,
  input  wire logic              csr_rd,
  input  wire logic [15:0]       csr_addr,
  input  wire logic [31:0]       csr_wdata,
  output var  logic [31:0]       csr_rdata,
  // Pipeline instructions
  input  wire logic              instr_enable,
  input  wire logic              instr_disable,
  input  wire logic              instr_begin_service_routine_instr,
  input  wire cic_pkg::cic_prio_t begin_service_routine_instr_prio,
  input  wire logic              instr_rfe,
  input  wire logic              rfe_ie,
  input  wire cic_pkg::cic_prio_t rfe_current_cpu_priority,
  // Interrupt take handshake
  input  wire logic [31:0]       vector_table_base,
  output logic                   irq_req,
  input  wire logic              irq_take,
  output var  logic [31:0]       vector_addr,
  output var  logic              saved_ie,
  output var  cic_pkg::cic_prio_t saved_current_cpu_priority,
  // Service request nodes
  input  wire logic [3:0]        hw_set,
  input  wire logic              node_wr,
  input  wire logic [2:0]        node_sel,
  input  wire logic [31:0]       node_wdata,
  output var  logic [7:0]        node_pending
);
  import cic_pkg::*;

  // ========================================================================
  // Node state, arbiter
  cic_node_if nif ();

  cic_nodes u_nodes (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .hw_set     (hw_set),
    .node_wr    (node_wr),
    .node_sel   (node_sel),
    .node_wdata (node_wdata),
    .nif        (nif)
  );

  cic_arbiter u_arb (
    .nif (nif)
  );

  // ========================================================================
  // Control register state
  logic      global_irq_enable;
  cic_prio_t current_cpu_priority;
  cic_prio_t pending_priority_number;
  logic [2:0] arb_ctrl;
  cic_idx_t  pend_idx;
  cic_arb_e  arb_state;
  logic [2:0] wait_cnt;

  logic      ic_hit_wr;
  logic      ic_hit_rd;
  logic      take_ok;
  logic      next_ie;
  cic_prio_t next_current_cpu_priority;
  logic [31:0] ic_value;
  logic [31:0] next_vec;

  assign ic_hit_wr = csr_wr && csr_addr == `CIC_IC_ADDR;
  assign ic_hit_rd = csr_rd && csr_addr == `CIC_IC_ADDR;

  // Reserved bits always zero
  assign ic_value = {5'h00, arb_ctrl, pending_priority_number, 7'h00,
                     global_irq_enable, current_cpu_priority};

  // Request only while pending strictly above CPU priority
  assign irq_req = arb_state == ARB_HOLD && global_irq_enable &&
                   pending_priority_number > current_cpu_priority;
  assign take_ok = irq_take && irq_req;

  // Entry = pending shifted five, ORed with base
  assign next_vec = vector_table_base |
                    {19'h0_0000, pending_priority_number, 5'h00};

  // Take first, then return, begin-routine, move, enable, disable
  always_comb begin
    next_ie   = global_irq_enable;
    next_current_cpu_priority = current_cpu_priority;
    if (take_ok) begin
      next_ie   = 1'b0;
      next_current_cpu_priority = pending_priority_number;
    end else if (instr_rfe) begin
      next_ie   = rfe_ie;
      next_current_cpu_priority = rfe_current_cpu_priority;
    end else if (instr_begin_service_routine_instr) begin
      next_ie   = 1'b1;
      next_current_cpu_priority = begin_service_routine_instr_prio;
    end else if (ic_hit_wr) begin
      next_ie   = csr_wdata[`CIC_IE_BIT];
      next_current_cpu_priority = csr_wdata[`CIC_CURRENT_CPU_PRIORITY_LSB +: 8];
    end else if (instr_enable) begin
      next_ie   = 1'b1;
    end else if (instr_disable) begin
      next_ie   = 1'b0;
    end
  end

  // Everything resets to zero
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      global_irq_enable    <= 1'b0;
      current_cpu_priority <= 8'h00;
    end else begin
      global_irq_enable    <= next_ie;
      current_cpu_priority <= next_current_cpu_priority;
    end
  end

  // Only move-to-core-register touches the arbitration control
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      arb_ctrl <= 3'h0;
    end else if (ic_hit_wr && !take_ok && !instr_rfe && !instr_begin_service_routine_instr) begin
      arb_ctrl <= csr_wdata[`CIC_ARBC_LSB +: 3];
    end
  end

  // ========================================================================
  // Arbitration rounds: clear, wait arb_ctrl cycles, publish, offer
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      arb_state <= ARB_START;
      wait_cnt  <= 3'h0;
    end else begin
      unique case (arb_state)
        ARB_START: begin
          wait_cnt  <= arb_ctrl;
          arb_state <= (arb_ctrl == 3'h0) ? ARB_END : ARB_WAIT;
        end
        ARB_WAIT: begin
          wait_cnt  <= wait_cnt - 3'h1;
          arb_state <= (wait_cnt == 3'h1) ? ARB_END : ARB_WAIT;
        end
        ARB_END:  arb_state <= ARB_HOLD;
        ARB_HOLD: arb_state <= ARB_START;
      endcase
    end
  end

  // Pending field cleared at round start, set at round end
  // No software path reaches the pending field
  // Continuous rounds re-offer a held request after return
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pending_priority_number <= 8'h00;
      pend_idx                <= 3'h0;
    end else if (arb_state == ARB_START) begin
      pending_priority_number <= 8'h00;
    end else if (arb_state == ARB_END) begin
      pending_priority_number <= nif.win_valid ? nif.win_prio : 8'h00;
      pend_idx                <= nif.win_idx;
    end
  end

  // Taken node's request is consumed; a new set wins over this clear
  assign nif.clr = take_ok ? (8'h01 << pend_idx) : 8'h00;

  // ========================================================================
  // Read data, vector and saved context
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      csr_rdata <= 32'h0000_0000;
    end else if (csr_rd) begin
      csr_rdata <= ic_hit_rd ? ic_value : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      vector_addr <= 32'h0000_0000;
      saved_ie    <= 1'b0;
      saved_current_cpu_priority  <= 8'h00;
    end else if (take_ok) begin
      vector_addr <= next_vec;
      saved_ie    <= global_irq_enable;
      saved_current_cpu_priority  <= current_cpu_priority;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      node_pending <= 8'h00;
    end else begin
      node_pending <= nif.req;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic only_csr;
  assign only_csr = !take_ok && !instr_rfe && !instr_begin_service_routine_instr;

  take_clears_ie_a: assert property (take_ok |=> !global_irq_enable)
    else $error("global enable not cleared on take");

  take_loads_current_cpu_priority_a: assert property (
    take_ok |=> current_cpu_priority == $past(pending_priority_number))
    else $error("CPU priority not loaded on take");

  vector_calc_a: assert property (
    take_ok |=> vector_addr == ($past(vector_table_base) |
                 {19'h0_0000, $past(pending_priority_number), 5'h00}))
    else $error("vector address wrong");

  req_gate_a: assert property (
    irq_req |-> global_irq_enable && pending_priority_number > current_cpu_priority)
    else $error("request offered at or below CPU priority");

  rfe_restore_a: assert property (
    instr_rfe && !take_ok |=> global_irq_enable == $past(rfe_ie) &&
                              current_cpu_priority == $past(rfe_current_cpu_priority))
    else $error("return did not restore context");

  begin_service_routine_instr_sets_a: assert property (
    instr_begin_service_routine_instr && !take_ok && !instr_rfe |=>
      global_irq_enable && current_cpu_priority == $past(begin_service_routine_instr_prio))
    else $error("begin-routine did not set enable and priority");

  move_current_cpu_priority_a: assert property (
    ic_hit_wr && only_csr |=> current_cpu_priority == $past(csr_wdata[7:0]))
    else $error("move did not write CPU priority");

  round_clear_a: assert property (
    arb_state == ARB_START |=> pending_priority_number == 8'h00)
    else $error("pending not cleared at round start");

  pend_readonly_a: assert property (
    arb_state inside {ARB_WAIT, ARB_HOLD} |=> $stable(pending_priority_number))
    else $error("pending changed outside round end");

  round_publish_a: assert property (
    arb_state == ARB_END |=> pending_priority_number == $past(nif.win_prio))
    else $error("pending not updated with winner");

  reserved_zero_a: assert property (
    csr_rd |=> csr_rdata[31:27] == 5'h00 && csr_rdata[15:9] == 7'h00)
    else $error("reserved bits not zero");

  sw_post_a: assert property (
    node_wr && node_sel >= 3'h4 && node_wdata[`CIC_ND_SET_BIT] |=> nif.req[$past(node_sel)])
    else $error("software post lost");

  hw_only_low_a: assert property (
    !node_wr && !$past(node_wr) |-> nif.req[7:4] == $past(nif.req[7:4]) ||
                                    nif.clr != 8'h00 || $past(nif.clr) != 8'h00)
    else $error("software-only node changed without software");

  reset_zero_a: assert property (@(posedge core_clk) disable iff (1'b0)
    !resetn |=> ic_value == `CIC_IC_RESET)
    else $error("control register not zero after reset");

  // Field writes, instruction effects and node flags
  arb_ctrl_move_a: assert property (
    ic_hit_wr && only_csr |=> arb_ctrl == $past(csr_wdata[26:24]))
    else $error("arbitration control not written");

  move_ie_a: assert property (
    ic_hit_wr && only_csr |=> global_irq_enable == $past(csr_wdata[8]))
    else $error("move did not write global enable");

  enable_instr_a: assert property (
    instr_enable && only_csr && !ic_hit_wr |=> global_irq_enable)
    else $error("enable instruction lost");

  disable_instr_a: assert property (
    instr_disable && !instr_enable && only_csr && !ic_hit_wr |=> !global_irq_enable)
    else $error("disable instruction lost");

  current_cpu_priority_hold_a: assert property (
    only_csr && !ic_hit_wr |=> $stable(current_cpu_priority))
    else $error("CPU priority changed without cause");

  saved_ctx_a: assert property (
    take_ok |=> saved_ie == $past(global_irq_enable) &&
                saved_current_cpu_priority == $past(current_cpu_priority))
    else $error("context before take not saved");

  take_consumes_a: assert property (
    take_ok && !node_wr && hw_set == 4'h0 |=> !nif.req[$past(pend_idx)])
    else $error("taken request not consumed");

  hw_set_req_a: assert property (
    hw_set != 4'h0 |=> (nif.req[3:0] & $past(hw_set)) == $past(hw_set))
    else $error("hardware post lost");

  idle_pending_zero_a: assert property (
    arb_state == ARB_END && !nif.win_valid |=> pending_priority_number == 8'h00)
    else $error("pending not zero with no request");

  winner_valid_a: assert property (
    nif.win_valid |-> nif.req[nif.win_idx] && nif.en[nif.win_idx] && nif.win_prio != 8'h00)
    else $error("winner not an enabled valid request");

  take_cov: cover property (take_ok);
  hw_take_cov: cover property (take_ok && pend_idx < 3'h4);
  prio_one_cov: cover property (take_ok && pending_priority_number == 8'h01 &&
                                current_cpu_priority == 8'h00);
  rfe_retake_cov: cover property (instr_rfe ##[1:12] take_ok);
  sw_take_cov: cover property (take_ok && pend_idx >= 3'h4);
endmodule
`default_nettype wire

/* design/cic_defines.svh */
// Offsets, field positions, reset values and counts of the interrupt control unit
`ifndef CIC_DEFINES_SVH
`define CIC_DEFINES_SVH

// ==========================================================================
// Interrupt control register
`define CIC_IC_ADDR       16'hfe2c
`define CIC_IC_RESET      32'h0000_0000
`define CIC_CURRENT_CPU_PRIORITY_LSB      0
`define CIC_IE_BIT        8
`define CIC_PENDING_PRIORITY_NUMBER_LSB      16
`define CIC_ARBC_LSB      24
// ==========================================================================
// Vector entry spacing and node counts
`define CIC_VEC_SHIFT     5
`define CIC_NUM_HW        4
`define CIC_NUM_SW        4
`define CIC_NUM_NODES     8
// ==========================================================================
// Node control word written by software
`define CIC_ND_PRIO_LSB   0
`define CIC_ND_EN_BIT     10
`define CIC_ND_CLR_BIT    14
`define CIC_ND_SET_BIT    15

`endif

/* design/cic_pkg.sv */
// Types shared by the interrupt control unit modules
package cic_pkg;
  typedef logic [7:0] cic_prio_t;
  typedef logic [2:0] cic_idx_t;
  typedef enum logic [1:0] {ARB_START, ARB_WAIT, ARB_END, ARB_HOLD} cic_arb_e;
endpackage

/* design/cic_node_if.sv */
// Signals between the request nodes, the arbiter and the control logic
`timescale 1ns/100ps
`default_nettype none
interface cic_node_if;
  import cic_pkg::*;
  logic [7:0]            req;
  logic [7:0]            en;
  cic_prio_t [7:0]       prio;
  logic [7:0]            clr;
  logic                  win_valid;
  cic_idx_t              win_idx;
  cic_prio_t             win_prio;
  modport nodes (output req, output en, output prio, input clr);
  modport arb   (input req, input en, input prio,
                 output win_valid, output win_idx, output win_prio);
  modport ctl   (input req, input win_valid, input win_idx, input win_prio, output clr);
endinterface
`default_nettype wire

/* design/cic_nodes.sv */
// Service request nodes: four peripheral-driven and four software-only
`timescale 1ns/100ps
`default_nettype none
`include "cic_defines.svh"
module cic_nodes (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Peripheral request pulses
  input  wire logic [3:0]  hw_set,
  // Software node writes
  input  wire logic        node_wr,
  input  wire logic [2:0]  node_sel,
  input  wire logic [31:0] node_wdata,
  // Node state
  cic_node_if.nodes        nif
);
  import cic_pkg::*;

  logic [7:0] sel_vec;
  logic [7:0] hw_vec;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] next_req;

  assign sel_vec  = node_wr ? (8'h01 << node_sel) : 8'h00;
  // Software-only nodes have no peripheral input at all
  assign hw_vec   = {4'h0, hw_set};
  // Software set enters the same flag as a hardware set
  assign set_vec  = hw_vec | (sel_vec & {8{node_wdata[`CIC_ND_SET_BIT]}});
  assign clr_vec  = nif.clr | (sel_vec & {8{node_wdata[`CIC_ND_CLR_BIT]}});
  // Set wins over a clear in the same cycle
  assign next_req = set_vec | (nif.req & ~clr_vec);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      nif.req <= 8'h00;
    end else begin
      nif.req <= next_req;
    end
  end

  for (genvar i = 0; i < `CIC_NUM_NODES; i++) begin : g_node
    always_ff @(posedge core_clk) begin
      if (!resetn) begin
        nif.en[i]   <= 1'b0;
        nif.prio[i] <= 8'h00;
      end else if (sel_vec[i]) begin
        nif.en[i]   <= node_wdata[`CIC_ND_EN_BIT];
        nif.prio[i] <= node_wdata[`CIC_ND_PRIO_LSB +: 8];
      end
    end
  end
endmodule
`default_nettype wire

/* design/cic_arbiter.sv */
// Highest-priority search over the enabled, requesting nodes
`timescale 1ns/100ps
`default_nettype none
`include "cic_defines.svh"
module cic_arbiter (
  // Node state and winner
  cic_node_if.arb nif
);
  import cic_pkg::*;

  always_comb begin
    nif.win_valid = 1'b0;
    nif.win_idx   = 3'h0;
    nif.win_prio  = 8'h00;
    for (int i = 0; i < `CIC_NUM_NODES; i++) begin
      // Node enable gates the request; priority zero is never valid
      if (nif.req[i] && nif.en[i] && nif.prio[i] > nif.win_prio) begin
        nif.win_valid = 1'b1;
        nif.win_idx   = i[2:0];
        nif.win_prio  = nif.prio[i];
      end
    end
  end
endmodule
`default_nettype wire

/* verif/cic_pipe_model.sv */
// Pipeline side model: takes offered interrupts, keeps return contexts
`timescale 1ns/100ps
`default_nettype none
module cic_pipe_model (
  // Clock
  input  wire logic               core_clk,
  // Offer and take
  input  wire logic               irq_req,
  input  wire logic               accept,
  output logic                    irq_take,
  output var  logic [7:0]         take_count,
  // Context saved at take, handed back at return
  input  wire logic               saved_ie,
  input  wire cic_pkg::cic_prio_t saved_current_cpu_priority,
  input  wire logic               instr_rfe,
  output logic                    rfe_ie,
  output cic_pkg::cic_prio_t      rfe_current_cpu_priority
);
  import cic_pkg::*;
  logic [8:0] ctx_stack [4];
  logic [1:0] depth = 2'd0;
  logic       took = 1'b0;
  logic [7:0] take_cnt = 8'h00;

  assign take_count = take_cnt;
  // A held-off pipeline simply lets offers pass by
  assign irq_take = irq_req & accept;
  // Context of the innermost routine goes back on return
  assign {rfe_ie, rfe_current_cpu_priority} = ctx_stack[depth - 2'd1];

  always @(posedge core_clk) begin
    took <= irq_take;
    if (irq_take) begin
      take_cnt <= take_cnt + 8'h01;
    end
    if (took) begin
      ctx_stack[depth] <= {saved_ie, saved_current_cpu_priority};
      depth <= depth + 2'd1;
    end else if (instr_rfe) begin
      depth <= depth - 2'd1;
    end
  end
endmodule
`default_nettype wire

/* verif/cic_top_tb.sv */
// Self-checking bench of the interrupt control unit
`timescale 1ns/100ps
`default_nettype none
`include "cic_defines.svh"
module cic_top_tb;
  import cic_pkg::*;
  logic        core_clk, resetn, csr_wr, csr_rd, irq_req, irq_take, accept;
  logic        instr_enable, instr_disable, instr_begin_service_routine_instr, instr_rfe, rfe_ie, saved_ie;
  logic [15:0] csr_addr;
  logic [31:0] csr_wdata, csr_rdata, vector_table_base, vector_addr, node_wdata, rd;
  cic_prio_t   begin_service_routine_instr_prio, rfe_current_cpu_priority, saved_current_cpu_priority;
  logic [3:0]  hw_set;
  logic [2:0]  node_sel;
  logic        node_wr;
  logic [7:0]  node_pending, take_count, exp_takes, hi, lo;
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;

  cic_top cic_top_inst (.core_clk(core_clk), .resetn(resetn), .csr_wr(csr_wr),
    .csr_rd(csr_rd), .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
    .instr_enable(instr_enable), .instr_disable(instr_disable), .instr_begin_service_routine_instr(instr_begin_service_routine_instr),
    .begin_service_routine_instr_prio(begin_service_routine_instr_prio), .instr_rfe(instr_rfe), .rfe_ie(rfe_ie), .rfe_current_cpu_priority(rfe_current_cpu_priority),
    .vector_table_base(vector_table_base), .irq_req(irq_req), .irq_take(irq_take),
    .vector_addr(vector_addr), .saved_ie(saved_ie), .saved_current_cpu_priority(saved_current_cpu_priority),
    .hw_set(hw_set), .node_wr(node_wr), .node_sel(node_sel), .node_wdata(node_wdata),
    .node_pending(node_pending));
  cic_pipe_model cic_pipe_model_inst (.core_clk(core_clk), .irq_req(irq_req),
    .accept(accept), .irq_take(irq_take), .take_count(take_count), .saved_ie(saved_ie),
    .saved_current_cpu_priority(saved_current_cpu_priority), .instr_rfe(instr_rfe), .rfe_ie(rfe_ie), .rfe_current_cpu_priority(rfe_current_cpu_priority));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Run limit
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // Access tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic csr_write(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    csr_wr <= 1'b1;
    csr_addr <= a;
    csr_wdata <= d;
    @(posedge core_clk);
    csr_wr <= 1'b0;
  endtask

  task automatic csr_read(input logic [15:0] a);
    @(posedge core_clk);
    csr_rd <= 1'b1;
    csr_addr <= a;
    @(posedge core_clk);
    csr_rd <= 1'b0;
    #1 rd = csr_rdata;
  endtask

  // Back-to-back reads past the longest round, keeps pending extremes
  task automatic read_burst();
    @(posedge core_clk);
    csr_rd <= 1'b1;
    csr_addr <= `CIC_IC_ADDR;
    hi = 8'h00;
    lo = 8'hff;
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk);
      if (i == 11) csr_rd <= 1'b0;
      #1;
      if (csr_rdata[23:16] > hi) hi = csr_rdata[23:16];
      if (csr_rdata[23:16] < lo) lo = csr_rdata[23:16];
    end
  endtask

  // 0 enable, 1 disable, 2 begin-routine, 3 return
  task automatic instr(input logic [1:0] which);
    @(posedge core_clk);
    {instr_rfe, instr_begin_service_routine_instr, instr_disable, instr_enable} <= 4'b0001 << which;
    @(posedge core_clk);
    {instr_rfe, instr_begin_service_routine_instr, instr_disable, instr_enable} <= 4'b0000;
  endtask

  task automatic node_write(input logic [2:0] sel, input logic s, input logic c,
                            input logic e, input logic [7:0] p);
    @(posedge core_clk);
    node_wr <= 1'b1;
    node_sel <= sel;
    node_wdata <= {16'h0000, s, c, 3'b000, e, 2'b00, p};
    @(posedge core_clk);
    node_wr <= 1'b0;
  endtask

  task automatic expect_take(input logic [2:0] sel, input logic [7:0] p,
                             input logic sie, input logic [7:0] sccpn);
    int n;
    n = 0;
    exp_takes = exp_takes + 8'h01;
    while (take_count !== exp_takes && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    #1;
    check(take_count, exp_takes);
    check(vector_addr, vector_table_base | (32'(p) << 5));
    check({saved_ie, saved_current_cpu_priority}, {sie, sccpn});
    csr_read(`CIC_IC_ADDR);
    check(rd & 32'h0000_01ff, 32'(p));
    check(node_pending[sel], 1'b0);
  endtask

  task automatic expect_quiet(input int n);
    repeat (n) @(posedge core_clk);
    #1;
    check(take_count, exp_takes);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    {resetn, csr_wr, csr_rd, node_wr, accept} = 5'b00000;
    {instr_enable, instr_disable, instr_begin_service_routine_instr, instr_rfe} = 4'b0000;
    {csr_addr, csr_wdata, node_wdata, node_sel, hw_set} = '0;
    begin_service_routine_instr_prio = 8'h33;
    vector_table_base = 32'h8000_0000;
    exp_takes = 8'h00;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    csr_read(`CIC_IC_ADDR);
    check(rd, 32'h0000_0000);
    csr_write(16'hfe20, 32'h0000_01ff);
    csr_read(16'hfe20);
    check(rd, 32'h0000_0000);
    csr_read(`CIC_IC_ADDR);
    check(rd, 32'h0000_0000);
    $display("test reset and unmapped done");

    csr_write(`CIC_IC_ADDR, 32'hffff_ffff);
    csr_read(`CIC_IC_ADDR);
    check(rd, 32'h0700_01ff);
    csr_write(`CIC_IC_ADDR, 32'h0000_0000);
    node_write(3'd5, 1'b1, 1'b0, 1'b1, 8'h42);
    read_burst();
    check(hi, 8'h42);
    check(lo, 8'h00);
    node_write(3'd5, 1'b0, 1'b1, 1'b0, 8'h00);
    $display("test register fields done");

    instr(2'd0);
    csr_read(`CIC_IC_ADDR);
    check(rd, 32'h0000_0100);
    instr(2'd1);
    csr_read(`CIC_IC_ADDR);
    check(rd, 32'h0000_0000);
    instr(2'd2);
    csr_read(`CIC_IC_ADDR);
    check(rd, 32'h0000_0133);
    $display("test instructions done");

    // Four sources under five priorities, software and hardware posting
    accept <= 1'b1;
    csr_write(`CIC_IC_ADDR, 32'h0000_0100);
    for (int i = 0; i < 5; i++) begin
      logic [2:0] s;
      logic [7:0] p;
      {s, p} = i == 0 ? {3'd4, 8'h01} : i == 1 ? {3'd4, 8'h20} : i == 2 ? {3'd0, 8'h40}
             : i == 3 ? {3'd7, 8'hff} : {3'd3, 8'h80};
      node_write(s, s > 3'd3, 1'b0, 1'b1, p);
      if (s < 3'd4) begin
        @(posedge core_clk);
        hw_set <= 4'b0001 << s[1:0];
        @(posedge core_clk);
        hw_set <= 4'b0000;
      end
      expect_take(s, p, 1'b1, 8'h00);
      instr(2'd3);
      csr_read(`CIC_IC_ADDR);
      check(rd & 32'h0000_01ff, 32'h0000_0100);
    end
    $display("test vector entries done");

    node_write(3'd6, 1'b1, 1'b0, 1'b1, 8'h60);
    expect_take(3'd6, 8'h60, 1'b1, 8'h00);
    node_write(3'd4, 1'b1, 1'b0, 1'b1, 8'h01);
    node_write(3'd5, 1'b1, 1'b0, 1'b1, 8'h30);
    expect_quiet(12);
    instr(2'd3);
    expect_take(3'd5, 8'h30, 1'b1, 8'h00);
    instr(2'd3);
    expect_take(3'd4, 8'h01, 1'b1, 8'h00);
    instr(2'd3);
    $display("test nested return done");

    csr_write(`CIC_IC_ADDR, 32'h0000_0150);
    node_write(3'd5, 1'b1, 1'b0, 1'b1, 8'h50);
    expect_quiet(12);
    node_write(3'd6, 1'b1, 1'b0, 1'b0, 8'h60);
    expect_quiet(12);
    csr_write(`CIC_IC_ADDR, 32'h0000_0050);
    node_write(3'd6, 1'b0, 1'b0, 1'b1, 8'h60);
    expect_quiet(12);
    instr(2'd0);
    expect_take(3'd6, 8'h60, 1'b1, 8'h50);
    instr(2'd3);
    csr_read(`CIC_IC_ADDR);
    check(rd & 32'h0000_01ff, 32'h0000_0150);
    $display("test priority gating done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
